// [pwmes_cfg.svh]
// register map, field positions and reset values of the pwm event status block
`ifndef PWMES_CFG_SVH
`define PWMES_CFG_SVH

`define PWMES_ADR_STATUS 32'h40020040
`define PWMES_ADR_IRQ_STAT 32'h40020044
`define PWMES_ADR_IRQ_EN 32'h40020048
`define PWMES_ADR_IRQ_CLR 32'h4002004C

`define PWMES_BIT_WRITE_READY 0
`define PWMES_BIT_TX_END 1
`define PWMES_BIT_TX_EMPTY 2
`define PWMES_BIT_UNDERRUN 3
`define PWMES_POS_MATCH 8
`define PWMES_POS_UPDATE 16

`define PWMES_USED_MASK 32'h00FFFF0F
`define PWMES_RST_WORD 32'h00000000
`define PWMES_RST_FLAG 1'h0
`define PWMES_RST_ZERO_PREV 1'h1
`define PWMES_NCMP_DOC 8
`define PWMES_CNT_W_DOC 16

`endif

// [pwmes_pkg.sv]
// types shared by the pwm event status block
package pwmes_pkg;

	typedef logic [31:0] pwmes_word_t;

	// classic wishbone request as seen by the slave
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [31:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} pwmes_wb_req_s;

	// one-cycle event pulses from the pwm core
	typedef struct packed {
		logic write_ready;
		logic underrun;
		logic [7:0] compare_match;
		logic [7:0] compare_update;
	} pwmes_evt_s;

	typedef enum logic [1:0] {
		PWMES_SEL_NONE = 2'b00,
		PWMES_SEL_STATUS = 2'b01,
		PWMES_SEL_IRQ = 2'b10,
		PWMES_SEL_EN = 2'b11
	} pwmes_rsel_e;

endpackage

// [pwmes_sticky.sv]
// sticky flag bank: set wins over clear
`timescale 1ns/1ps
module pwmes_sticky #(
	parameter int W = 1
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] flag_q;
	logic [W-1:0] flag_d;

	// an event in the clearing cycle survives
	assign flag_d = set_i | (flag_q & ~clr_i);
	assign q_o = flag_q;

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			flag_q <= '0;
		end else begin
			flag_q <= flag_d;
		end
	end
endmodule

// [pwmes_top.sv]
// pwm event status register with wishbone slave and interrupt
`timescale 1ns/1ps
`include "pwmes_cfg.svh"

// Contract
// - bit0 shows synchronous update may be written
// - bit1 set when tx counter reaches zero
// - bit2 zero while either tx counter nonzero
// - bit3 latches underrun until next read
// - bits 8..15 latch compare match until read
// - bits 16..23 latch compare update until read
// - status read clears ready, underrun, compare flags
module pwmes_top #(
	parameter int NCMP = `PWMES_NCMP_DOC,
	parameter int CNT_W = `PWMES_CNT_W_DOC
) (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire pwmes_pkg::pwmes_wb_req_s wb_req_i,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire pwmes_pkg::pwmes_evt_s evt_i,
	input wire logic [CNT_W-1:0] tx_counter_i,
	input wire logic [CNT_W-1:0] tx_next_counter_i,
	input wire logic peripheral_dma_channel_write_i,
	output logic irq_o
);

	generate
		if (NCMP != `PWMES_NCMP_DOC) begin : g_bad_ncmp
			$error("pwmes_top: the status layout holds exactly eight comparisons");
		end
		if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
			$error("pwmes_top: counter width must be 1 to 32");
		end
	endgenerate

	// bus side
	logic ack_q;
	logic [31:0] dat_q;
	wire req_new = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
	wire hit_status = wb_req_i.adr == `PWMES_ADR_STATUS;
	wire hit_irq_stat = wb_req_i.adr == `PWMES_ADR_IRQ_STAT;
	wire hit_irq_en = wb_req_i.adr == `PWMES_ADR_IRQ_EN;
	wire hit_irq_clr = wb_req_i.adr == `PWMES_ADR_IRQ_CLR;
	wire rd_take = req_new & ~wb_req_i.we;
	wire wr_take = req_new & wb_req_i.we;
	wire status_rd = rd_take & hit_status;
	wire [31:0] lane_mask = {{8{wb_req_i.sel[3]}}, {8{wb_req_i.sel[2]}},
		{8{wb_req_i.sel[1]}}, {8{wb_req_i.sel[0]}}};

	// status flags
	logic write_ready_flag;
	logic underrun_flag;
	logic [NCMP-1:0] match_flag;
	logic [NCMP-1:0] update_flag;
	logic tx_end_q;
	logic tx_zero_prev_q;
	logic tx_empty_q;
	logic [31:0] irq_stat;
	logic [31:0] irq_en_q;

	pwmes_sticky #(
		.W(2 + 2 * NCMP)
	) u_status_flags (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.set_i({evt_i.compare_update, evt_i.compare_match, evt_i.underrun,
			evt_i.write_ready}),
		.clr_i({(2 + 2 * NCMP){status_rd}}),
		.q_o({update_flag, match_flag, underrun_flag, write_ready_flag})
	);

	// end of transfer: the counter reaching zero is the event; a fresh dma
	// programming write clears it, but a zero reached in that cycle still sets
	wire tx_zero = tx_counter_i == '0;
	wire tx_reach = tx_zero & ~tx_zero_prev_q;
	wire tx_end_d = tx_reach | (tx_end_q & ~peripheral_dma_channel_write_i);
	wire tx_empty_d = tx_zero & (tx_next_counter_i == '0);

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			tx_end_q <= `PWMES_RST_FLAG;
			tx_zero_prev_q <= `PWMES_RST_ZERO_PREV;
			tx_empty_q <= `PWMES_RST_FLAG;
		end else begin
			tx_end_q <= tx_end_d;
			tx_zero_prev_q <= tx_zero;
			tx_empty_q <= tx_empty_d;
		end
	end

	// reserved positions stay zero by construction
	wire [31:0] status_word = {8'h00, update_flag, match_flag, 4'h0, underrun_flag,
		tx_empty_q, tx_end_q, write_ready_flag};

	// interrupt events use the status layout; rising levels count as events
	logic tx_empty_prev_q;
	wire [31:0] irq_evt = {8'h00, evt_i.compare_update, evt_i.compare_match, 4'h0,
		evt_i.underrun, tx_empty_d & ~tx_empty_prev_q, tx_reach, evt_i.write_ready};
	wire [31:0] irq_clr = (wr_take & hit_irq_clr) ? (wb_req_i.dat & lane_mask)
		: 32'h00000000;

	pwmes_sticky #(
		.W(32)
	) u_irq_flags (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.set_i(irq_evt & `PWMES_USED_MASK),
		.clr_i(irq_clr),
		.q_o(irq_stat)
	);

	wire [31:0] irq_en_d = (wr_take & hit_irq_en)
		? (((wb_req_i.dat & lane_mask) | (irq_en_q & ~lane_mask)) & `PWMES_USED_MASK)
		: irq_en_q;

	// read mux; unmapped and write-only addresses read zero
	wire pwmes_pkg::pwmes_rsel_e rsel = hit_status ? pwmes_pkg::PWMES_SEL_STATUS
		: hit_irq_stat ? pwmes_pkg::PWMES_SEL_IRQ
		: hit_irq_en ? pwmes_pkg::PWMES_SEL_EN
		: pwmes_pkg::PWMES_SEL_NONE;
	logic [31:0] rdata;
	always_comb begin
		unique case (rsel)
			pwmes_pkg::PWMES_SEL_STATUS: rdata = status_word;
			pwmes_pkg::PWMES_SEL_IRQ: rdata = irq_stat;
			pwmes_pkg::PWMES_SEL_EN: rdata = irq_en_q;
			pwmes_pkg::PWMES_SEL_NONE: rdata = `PWMES_RST_WORD;
		endcase
	end

	// one wait-free answer: ack the edge after the request, drop it the next
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			ack_q <= `PWMES_RST_FLAG;
			dat_q <= `PWMES_RST_WORD;
			irq_en_q <= `PWMES_RST_WORD;
			tx_empty_prev_q <= `PWMES_RST_FLAG;
		end else begin
			ack_q <= req_new;
			dat_q <= rd_take ? rdata : `PWMES_RST_WORD;
			irq_en_q <= irq_en_d;
			tx_empty_prev_q <= tx_empty_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	assign irq_o = |(irq_stat & irq_en_q);

	// checks
	a_ready_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		evt_i.write_ready |=> write_ready_flag)
		else $error("write ready event not latched");

	a_tx_end_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		tx_reach |=> tx_end_q)
		else $error("transfer end not set after counter reached zero");

	a_tx_end_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		tx_end_q && !peripheral_dma_channel_write_i |=> tx_end_q)
		else $error("transfer end dropped without a dma write");

	a_tx_end_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		peripheral_dma_channel_write_i && !(tx_zero && !tx_zero_prev_q) |=> !tx_end_q)
		else $error("transfer end not cleared by dma write");

	a_tx_empty_lvl: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(tx_counter_i != '0 || tx_next_counter_i != '0) |=> !tx_empty_q)
		else $error("buffer empty shown while a counter is nonzero");

	a_tx_empty_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(tx_counter_i == '0 && tx_next_counter_i == '0) |=> tx_empty_q)
		else $error("buffer empty missing with both counters zero");

	a_underrun_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		underrun_flag && !status_rd |=> underrun_flag)
		else $error("underrun dropped without a status read");

	a_underrun_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		evt_i.underrun ##1 !status_rd[*2] |=> underrun_flag)
		else $error("underrun not held until read");

	a_match_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		|evt_i.compare_match |=> (match_flag & $past(evt_i.compare_match))
			== $past(evt_i.compare_match))
		else $error("compare match not latched");

	a_match_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!status_rd |=> (match_flag & ~$past(match_flag)) == $past(evt_i.compare_match
			& ~match_flag))
		else $error("compare match flags changed without event or read");

	a_update_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		|evt_i.compare_update |=> (update_flag & $past(evt_i.compare_update))
			== $past(evt_i.compare_update))
		else $error("compare update not latched");

	a_read_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		status_rd && !evt_i.underrun && evt_i.compare_match == '0 |=>
			wb_ack_o && !underrun_flag && match_flag == '0)
		else $error("status read did not clear flags");

	a_read_return: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		status_rd |=> wb_dat_o == $past(status_word))
		else $error("status read returned wrong word");

	a_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		wb_ack_o && $past(status_rd) |-> wb_dat_o[7:4] == 4'h0
			&& wb_dat_o[31:24] == 8'h00)
		else $error("reserved status bits not zero");

	a_ack_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	a_irq_level: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		|(irq_stat & irq_en_q) == irq_o)
		else $error("interrupt output does not follow enabled status");

	// flag checks: each flag moves only on its own event or its own clear
	a_tx_end_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!tx_reach && !tx_end_q
		|=> !tx_end_q)
		else $error("transfer end set without the counter reaching zero");

	a_tx_reach_once: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		tx_reach
		|=> !tx_reach)
		else $error("zero crossing of the counter seen twice");

	a_ready_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		write_ready_flag && !status_rd
		|=> write_ready_flag)
		else $error("write ready dropped without a status read");

	a_ready_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!evt_i.write_ready && !write_ready_flag
		|=> !write_ready_flag)
		else $error("write ready set without an event");

	a_ready_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		status_rd && !evt_i.write_ready
		|=> !write_ready_flag)
		else $error("write ready not cleared by status read");

	a_underrun_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!evt_i.underrun && !underrun_flag
		|=> !underrun_flag)
		else $error("underrun set without an event");

	a_underrun_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		status_rd && evt_i.underrun
		|=> underrun_flag)
		else $error("underrun in the read cycle was lost");

	a_match_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!status_rd
		|=> (match_flag & $past(match_flag)) == $past(match_flag))
		else $error("compare match dropped without a status read");

	a_match_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		status_rd
		|=> match_flag == $past(evt_i.compare_match))
		else $error("compare match after read differs from read cycle events");

	a_update_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!status_rd
		|=> (update_flag & $past(update_flag)) == $past(update_flag))
		else $error("compare update dropped without a status read");

	a_update_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!status_rd
		|=> (update_flag & ~$past(update_flag)) == $past(evt_i.compare_update & ~update_flag))
		else $error("compare update flags changed without event or read");

	a_update_wins: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		status_rd
		|=> update_flag == $past(evt_i.compare_update))
		else $error("compare update after read differs from read cycle events");

	a_update_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		status_rd && evt_i.compare_update == '0
		|=> update_flag == '0)
		else $error("compare update not cleared by status read");

	a_write_no_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		wr_take && hit_status
		|=> (match_flag & $past(match_flag)) == $past(match_flag))
		else $error("write to status cleared compare match flags");

	// bus answer checks
	a_reserved_all: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		wb_ack_o
		|-> (wb_dat_o & ~`PWMES_USED_MASK) == 32'h00000000)
		else $error("reserved bit set in read data");

	a_dat_idle: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!wb_ack_o
		|-> wb_dat_o == 32'h00000000)
		else $error("read data not zero outside an answer");

	a_ack_answer: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		req_new
		|=> wb_ack_o)
		else $error("request not answered in the next cycle");

	a_ack_quiet: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!(wb_req_i.cyc && wb_req_i.stb)
		|=> !wb_ack_o)
		else $error("ack without a request");

	a_unmapped_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		rd_take && rsel == pwmes_pkg::PWMES_SEL_NONE
		|=> wb_dat_o == 32'h00000000)
		else $error("unmapped read returned nonzero data");

	// interrupt checks
	a_en_reserved: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(irq_en_q & ~`PWMES_USED_MASK)
		== 32'h00000000)
		else $error("reserved enable bit set");

	a_en_write: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		wr_take && hit_irq_en && wb_req_i.sel == 4'hF
		|=> irq_en_q == ($past(wb_req_i.dat) & `PWMES_USED_MASK))
		else $error("enable write not taken");

	a_en_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		!(wr_take && hit_irq_en)
		|=> $stable(irq_en_q))
		else $error("enable changed without a write");

	a_irq_set: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		|(irq_evt & `PWMES_USED_MASK)
		|=> (irq_stat & $past(irq_evt & `PWMES_USED_MASK)) == $past(irq_evt & `PWMES_USED_MASK))
		else $error("interrupt event not latched");

	a_irq_clear: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		wr_take && hit_irq_clr && (irq_evt & `PWMES_USED_MASK) == 32'h00000000
		|=> (irq_stat & $past(irq_clr)) == 32'h00000000)
		else $error("interrupt status not cleared by clear write");

	a_irq_rd_keep: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		status_rd
		|=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
		else $error("status read disturbed interrupt status");

endmodule

// [pwmes_top_bench.sv]
// self-checking bench for the pwm event status register
`timescale 1ns/1ps
`include "pwmes_cfg.svh"
module pwmes_top_bench;
	typedef struct packed {
		pwmes_pkg::pwmes_evt_s ev;
		logic [31:0] exp;
	} pwmes_row_s;
	logic clk_sys_i = 1'b0;
	logic rst_b_i;
	pwmes_pkg::pwmes_wb_req_s wb_req;
	pwmes_pkg::pwmes_evt_s evt;
	logic wb_ack;
	logic irq;
	logic dma_wr;
	logic [31:0] wb_dat;
	logic [31:0] rd;
	logic [15:0] tx_cnt;
	logic [15:0] tx_nxt;
	int failures;
	int checks_done;
	int cycles;
	pwmes_row_s rows [5];

	always #20 clk_sys_i = ~clk_sys_i;

	pwmes_top u_pwmes_top (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.wb_req_i(wb_req),
		.wb_ack_o(wb_ack),
		.wb_dat_o(wb_dat),
		.evt_i(evt),
		.tx_counter_i(tx_cnt),
		.tx_next_counter_i(tx_nxt),
		.peripheral_dma_channel_write_i(dma_wr),
		.irq_o(irq)
	);

	task automatic summarize();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// request held until the edge that sees ack, released right after it
	task automatic wbs(input logic we, input logic [31:0] adr, input logic [31:0] dat,
		input logic [3:0] sel);
		@(posedge clk_sys_i);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: sel, dat: dat};
		do @(posedge clk_sys_i); while (wb_ack !== 1'b1);
		rd = wb_dat;
		wb_req <= '0;
	endtask

	task automatic wb(input logic we, input logic [31:0] adr, input logic [31:0] dat);
		wbs(we, adr, dat, 4'hF);
	endtask

	task automatic rs(input string nm, input logic [31:0] exp);
		wb(1'b0, `PWMES_ADR_STATUS, 32'h00000000);
		chk(nm, rd, exp);
	endtask

	task automatic pulse(input pwmes_pkg::pwmes_evt_s v);
		@(posedge clk_sys_i);
		evt <= v;
		@(posedge clk_sys_i);
		evt <= '0;
	endtask

	// generous ceiling: the whole sequence needs under two hundred cycles
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			summarize();
		end
	end

	initial begin
		rst_b_i = 1'b0;
		wb_req = '0;
		evt = '0;
		dma_wr = 1'b0;
		tx_cnt = 16'h0005;
		tx_nxt = 16'h0003;
		failures = 0;
		checks_done = 0;
		rows[0] = '{'{1'b1, 1'b0, 8'h00, 8'h00}, 32'h00000001};
		rows[1] = '{'{1'b0, 1'b1, 8'h00, 8'h00}, 32'h00000008};
		rows[2] = '{'{1'b0, 1'b0, 8'h81, 8'h00}, 32'h00008100};
		rows[3] = '{'{1'b0, 1'b0, 8'h00, 8'h5A}, 32'h005A0000};
		rows[4] = '{'{1'b1, 1'b1, 8'hFF, 8'hFF}, 32'h00FFFF09};
		repeat (10) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		rs("status after reset", 32'h00000000);
		foreach (rows[i]) begin
			pulse(rows[i].ev);
			rs("status flags", rows[i].exp);
			rs("status after read", 32'h00000000);
		end
		// an event in the very cycle of a status read must survive that read
		fork
			rs("underrun at read", 32'h00000000);
			pulse('{1'b0, 1'b1, 8'h00, 8'h00});
		join
		rs("underrun kept", 32'h00000008);
		rs("underrun cleared", 32'h00000000);
		wb(1'b1, `PWMES_ADR_IRQ_CLR, 32'hFFFFFFFF);
		wb(1'b1, `PWMES_ADR_IRQ_EN, 32'hFFFFFFFF);
		wb(1'b0, `PWMES_ADR_IRQ_EN, 32'h00000000);
		chk("enable readback", rd, `PWMES_USED_MASK);
		wb(1'b1, `PWMES_ADR_IRQ_EN, 32'h00000008);
		chk("irq idle", {31'h0, irq}, 32'h00000000);
		pulse('{1'b0, 1'b1, 8'h00, 8'h00});
		@(negedge clk_sys_i);
		chk("irq raised", {31'h0, irq}, 32'h00000001);
		rs("status on irq", 32'h00000008);
		chk("irq after status read", {31'h0, irq}, 32'h00000001);
		wb(1'b0, `PWMES_ADR_IRQ_STAT, 32'h00000000);
		chk("irq status", rd, 32'h00000008);
		wb(1'b1, `PWMES_ADR_IRQ_CLR, 32'h00000008);
		chk("irq cleared", {31'h0, irq}, 32'h00000000);
		wb(1'b1, `PWMES_ADR_IRQ_EN, 32'h00000000);
		pulse('{1'b0, 1'b1, 8'h00, 8'h00});
		@(negedge clk_sys_i);
		chk("irq masked", {31'h0, irq}, 32'h00000000);
		rs("masked underrun", 32'h00000008);
		// transmit counters: end flag survives reads, empty needs both at zero
		@(posedge clk_sys_i);
		tx_cnt <= 16'h0000;
		rs("transfer end", 32'h00000002);
		rs("transfer end kept", 32'h00000002);
		@(posedge clk_sys_i);
		tx_nxt <= 16'h0000;
		rs("buffer empty", 32'h00000006);
		@(posedge clk_sys_i);
		tx_cnt <= 16'h0005;
		dma_wr <= 1'b1;
		@(posedge clk_sys_i);
		dma_wr <= 1'b0;
		rs("after dma write", 32'h00000000);
		wb(1'b1, `PWMES_ADR_STATUS, 32'hFFFFFFFF);
		rs("status write ignored", 32'h00000000);
		wb(1'b0, 32'h40020050, 32'h00000000);
		chk("unmapped read", rd, 32'h00000000);
		// byte lanes gate enable and clear writes
		wbs(1'b1, `PWMES_ADR_IRQ_EN, 32'hFFFFFFFF, 4'h2);
		wb(1'b0, `PWMES_ADR_IRQ_EN, 32'h00000000);
		chk("enable byte lane", rd, 32'h0000FF00);
		wbs(1'b1, `PWMES_ADR_IRQ_CLR, 32'hFFFFFFFF, 4'hE);
		wb(1'b0, `PWMES_ADR_IRQ_STAT, 32'h00000000);
		chk("clear upper lanes", rd, 32'h0000000E);
		wbs(1'b1, `PWMES_ADR_IRQ_CLR, 32'hFFFFFFFF, 4'h1);
		wb(1'b0, `PWMES_ADR_IRQ_STAT, 32'h00000000);
		chk("clear low lane", rd, 32'h00000000);
		// second reset in mid-run returns flags, enable and interrupt to zero
		pulse('{1'b1, 1'b1, 8'hFF, 8'hFF});
		wb(1'b1, `PWMES_ADR_IRQ_EN, 32'hFFFFFFFF);
		chk("irq before reset", {31'h0, irq}, 32'h00000001);
		@(posedge clk_sys_i);
		rst_b_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		chk("ack in reset", {31'h0, wb_ack}, 32'h00000000);
		chk("irq in reset", {31'h0, irq}, 32'h00000000);
		rst_b_i <= 1'b1;
		rs("status after second reset", 32'h00000000);
		wb(1'b0, `PWMES_ADR_IRQ_EN, 32'h00000000);
		chk("enable after reset", rd, 32'h00000000);
		wb(1'b0, `PWMES_ADR_IRQ_STAT, 32'h00000000);
		chk("irq status after reset", rd, 32'h00000000);
		summarize();
	end
endmodule
